/* logic/ais_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Select write holds strobe low across whole select pulse
// - Address constant for whole write cycle
// - Address settled before select starts write
// - Select held low its minimum width
// - Write data valid before terminating edge
// - Write data held after strobe ends
// - Select or strobe high at address change
// - Strobe write waits drivers off plus setup
// - Select write needs only pulse width
// - Read address held one read cycle
// - Strobe high before select for read
// - Select held one read cycle
module ais_ctrl
	import ais_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_sys_rst,
	input  wire logic              i_ce,
	input  wire logic              i_req_valid,
	input  wire ais_req_type       i_req,
	output var  logic              o_req_ready,
	output var  logic              o_rd_valid,
	output var  logic [DATA_W-1:0] o_rd_data,
	output var  logic              o_sel_n,
	output var  logic              o_wr_n,
	output var  logic [ADDR_W-1:0] o_addr,
	output var  logic [DATA_W-1:0] o_dq,
	output var  logic              o_dq_oe_n,
	input  wire logic [DATA_W-1:0] i_dq
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_PULSE = 3'b011,
		ST_HOLD  = 3'b010,
		ST_RECOV = 3'b110
	} ais_state_type;

	ais_state_type     state_q;
	ais_state_type     state_d;
	logic [CNT_W-1:0]  cnt_q;
	logic [CNT_W-1:0]  cnt_d;
	logic [CNT_W-1:0]  cyc_q;
	logic [CNT_W-1:0]  cyc_d;
	logic              write_q;
	ais_wmode_type     wmode_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] dq_sync;
	ais_pins_type      pins_d;
	logic              rd_valid_d;
	logic              rd_capture;

	// Pin data comes from outside the clock domain
	ais_sync #(
		.WIDTH(DATA_W)
	) u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_ce      (i_ce),
		.i_d       (i_dq),
		.o_q       (dq_sync)
	);

	// Pulse length per kind of access
	localparam logic [CNT_W-1:0] SETUP_LEN  = CNT_W'(AS_CYC > RCS_CYC ? AS_CYC : RCS_CYC);
	localparam int unsigned SEL_W_PULSE = (WP_CYC > CW_CYC ? WP_CYC : CW_CYC) > DW_CYC
		? (WP_CYC > CW_CYC ? WP_CYC : CW_CYC) : DW_CYC;
	localparam int unsigned STB_W_PULSE = (WZ_CYC + DW_CYC) > SEL_W_PULSE
		? (WZ_CYC + DW_CYC) : SEL_W_PULSE;
	// Two sync stages delay read data; hold select long enough to capture it
	localparam int unsigned RD_ACC = (AA_CYC > ACS_CYC ? AA_CYC : ACS_CYC) + 2;
	localparam int unsigned RD_PULSE_I = RD_ACC > RC_CYC ? RD_ACC : RC_CYC;
	localparam logic [CNT_W-1:0] RD_PULSE  = CNT_W'(RD_PULSE_I);
	localparam logic [CNT_W-1:0] SELW_LEN  = CNT_W'(SEL_W_PULSE);
	localparam logic [CNT_W-1:0] STBW_LEN  = CNT_W'(STB_W_PULSE);
	localparam logic [CNT_W-1:0] HOLD_LEN  = CNT_W'(DH_CYC);
	localparam logic [CNT_W-1:0] WCYC_LEN  = CNT_W'(WC_CYC);
	localparam logic [CNT_W-1:0] RECOV_LEN = CNT_W'(HZ_CYC);
	localparam logic [CNT_W-1:0] ONE       = CNT_W'(1);
	localparam logic [CNT_W-1:0] STB_DATA_AT = SETUP_LEN + CNT_W'(WZ_CYC);

	// Taken only after ready has shown, so nothing slips in straight after reset
	wire take_req  = (state_q == ST_IDLE) && i_req_valid && o_req_ready;
	wire cnt_done  = (cnt_q == ONE);
	wire is_stb_wr = write_q && (wmode_q == AIS_WR_STROBE);
	wire [CNT_W-1:0] pulse_len = !write_q ? RD_PULSE : (is_stb_wr ? STBW_LEN : SELW_LEN);

	// Pins are set a cycle ahead, so the request being taken steers them
	wire              nx_write  = take_req ? i_req.write : write_q;
	wire              nx_stb    = nx_write
		&& ((take_req ? i_req.wmode : wmode_q) == AIS_WR_STROBE);
	wire [DATA_W-1:0] nx_wdata  = take_req ? i_req.wdata : wdata_q;
	wire              nx_active = (state_d != ST_IDLE) && (state_d != ST_RECOV);
	// Strobe writes only drive data once the memory has let go
	wire data_drive = nx_write && nx_active
		&& (!nx_stb || (state_d != ST_PULSE) || (cyc_d >= STB_DATA_AT));
	// Address cycle may not close before the write cycle time
	wire wc_met = !write_q || (cyc_q >= WCYC_LEN);

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_done ? cnt_q : cnt_q - ONE;
		cyc_d   = (cyc_q == '1) ? cyc_q : cyc_q + ONE;
		case (state_q)
			ST_IDLE: begin
				cyc_d = '0;
				if (take_req) begin
					state_d = ST_SETUP;
					cnt_d   = SETUP_LEN;
				end
			end
			ST_SETUP: begin
				if (cnt_done) begin
					state_d = ST_PULSE;
					cnt_d   = pulse_len;
				end
			end
			ST_PULSE: begin
				if (cnt_done) begin
					state_d = ST_HOLD;
					cnt_d   = HOLD_LEN;
				end
			end
			ST_HOLD: begin
				if (cnt_done && wc_met) begin
					state_d = ST_RECOV;
					cnt_d   = RECOV_LEN;
				end
			end
			ST_RECOV: begin
				if (cnt_done) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Pin levels for the next cycle
	always_comb begin
		pins_d.addr    = o_addr;
		pins_d.sel_n   = 1'b1;
		pins_d.wr_n    = 1'b1;
		pins_d.dq_o    = nx_wdata;
		pins_d.dq_oe_n = !data_drive;
		if (take_req) begin
			pins_d.addr = i_req.addr;
		end
		case (state_d)
			ST_PULSE: begin
				pins_d.sel_n = 1'b0;
				// Select write keeps strobe low all through select
				pins_d.wr_n  = !nx_write;
			end
			ST_SETUP: begin
				// Select stays high so the new address settles first
				// Select write lowers strobe early; reads keep it high
				pins_d.wr_n  = !(nx_write && !nx_stb);
			end
			ST_HOLD: begin
				// Strobe write keeps select low through the data hold
				pins_d.sel_n = !nx_stb;
			end
			default: begin
			end
		endcase
	end

	// Read data sampled at the close of the select pulse
	assign rd_capture = (state_q == ST_PULSE) && cnt_done && !write_q;
	assign rd_valid_d = rd_capture;

	// Clock enable low freezes every flop below
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_q <= ST_IDLE;
		end else if (i_ce) begin
			state_q <= state_d;
		end
	end

	// Counter rests at one once a phase is done
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cnt_q <= '0;
		end else if (i_ce) begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cyc_q <= '0;
		end else if (i_ce) begin
			cyc_q <= cyc_d;
		end
	end

	// Request fields held for the whole access
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			write_q <= 1'b0;
		end else if (i_ce && take_req) begin
			write_q <= i_req.write;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			wmode_q <= AIS_WR_SELECT;
		end else if (i_ce && take_req) begin
			wmode_q <= i_req.wmode;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			wdata_q <= '0;
		end else if (i_ce && take_req) begin
			wdata_q <= i_req.wdata;
		end
	end

	// Every pin straight from a flop, so no decode glitch reaches the memory
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_sel_n <= 1'b1;
		end else if (i_ce) begin
			o_sel_n <= pins_d.sel_n;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_wr_n <= 1'b1;
		end else if (i_ce) begin
			o_wr_n <= pins_d.wr_n;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_addr <= '0;
		end else if (i_ce) begin
			o_addr <= pins_d.addr;
		end
	end

	// Data pins follow the stored word; the enable decides who owns them
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_dq <= '0;
		end else if (i_ce) begin
			o_dq <= pins_d.dq_o;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_dq_oe_n <= 1'b1;
		end else if (i_ce) begin
			o_dq_oe_n <= pins_d.dq_oe_n;
		end
	end

	// Ready mirrors idle; a request is taken only while it shows
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_req_ready <= 1'b0;
		end else if (i_ce) begin
			o_req_ready <= (state_d == ST_IDLE);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rd_valid <= 1'b0;
		end else if (i_ce) begin
			o_rd_valid <= rd_valid_d;
		end
	end

	// Last read word stays until the next read
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rd_data <= '0;
		end else if (i_ce) begin
			if (rd_capture) begin
				o_rd_data <= dq_sync;
			end
		end
	end
endmodule
`default_nettype wire

/* logic/ais_pkg.sv */
`default_nettype none
package ais_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;
	// Pin timing figures in ns; counts derived below
	localparam int unsigned WRITE_PULSE_NS = 20;
	localparam int unsigned WRITE_CYCLE_NS = 40;
	localparam int unsigned ADDRESS_SETUP_TIME_NS = 0;
	localparam int unsigned SELECT_TO_WRITE_END_NS = 20;
	localparam int unsigned DATA_VALID_TO_WRITE_END_TIME_NS = 13;
	localparam int unsigned DATA_HOLD_TIME_NS = 0;
	localparam int unsigned WRITE_TO_OUTPUT_OFF_NS = 10;
	localparam int unsigned READ_CYCLE_TIME_NS = 40;
	localparam int unsigned READ_COMMAND_SETUP_TIME_NS = 0;
	localparam int unsigned ADDRESS_ACCESS_TIME_NS = 35;
	localparam int unsigned SELECT_ACCESS_NS = 35;
	localparam int unsigned DESELECT_TO_OUTPUT_OFF_NS = 10;

	function automatic int unsigned ais_min_cycles(input int unsigned ns);
		int unsigned c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int unsigned AS_CYC  = ais_min_cycles(ADDRESS_SETUP_TIME_NS);
	localparam int unsigned WP_CYC  = ais_min_cycles(WRITE_PULSE_NS);
	localparam int unsigned CW_CYC  = ais_min_cycles(SELECT_TO_WRITE_END_NS);
	localparam int unsigned DW_CYC  = ais_min_cycles(DATA_VALID_TO_WRITE_END_TIME_NS);
	localparam int unsigned WZ_CYC  = ais_min_cycles(WRITE_TO_OUTPUT_OFF_NS);
	localparam int unsigned DH_CYC  = ais_min_cycles(DATA_HOLD_TIME_NS);
	localparam int unsigned WC_CYC  = ais_min_cycles(WRITE_CYCLE_NS);
	localparam int unsigned RC_CYC  = ais_min_cycles(READ_CYCLE_TIME_NS);
	localparam int unsigned RCS_CYC = ais_min_cycles(READ_COMMAND_SETUP_TIME_NS);
	localparam int unsigned AA_CYC  = ais_min_cycles(ADDRESS_ACCESS_TIME_NS);
	localparam int unsigned ACS_CYC = ais_min_cycles(SELECT_ACCESS_NS);
	localparam int unsigned HZ_CYC  = ais_min_cycles(DESELECT_TO_OUTPUT_OFF_NS);

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 4;
	localparam int unsigned CNT_W  = 8;

	typedef enum logic [1:0] {
		AIS_WR_SELECT = 2'b00,
		AIS_WR_STROBE = 2'b01
	} ais_wmode_type;

	typedef struct packed {
		logic                write;
		ais_wmode_type       wmode;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
	} ais_req_type;

	typedef struct packed {
		logic                sel_n;
		logic                wr_n;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   dq_o;
		logic                dq_oe_n;
	} ais_pins_type;
endpackage
`default_nettype wire

/* logic/ais_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for the shared data pins
module ais_sync
	import ais_pkg::*;
#(
	parameter int unsigned WIDTH = DATA_W
) (
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_ce,
	input  wire logic [WIDTH-1:0] i_d,
	output var  logic [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			o_q    <= '0;
		end else if (i_ce) begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* tb/ais_sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ais_sram_model
	import ais_pkg::*;
#(
	parameter int unsigned DLY_NS = 30
) (
	input  wire logic              i_sel_n,
	input  wire logic              i_wr_n,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_dq,
	output var  logic [DATA_W-1:0] o_dq,
	output var  logic              o_drive
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [DATA_W-1:0] rd_q;
	logic [DATA_W-1:0] last_q = '0;
	logic              on_q;
	wire               wen = !i_sel_n && !i_wr_n;
	wire               rd_en = !i_sel_n && i_wr_n;
	// Slow turn-on but prompt release, the worst case for the controller
	assign #(DLY_NS) on_q = rd_en;
	assign #(DLY_NS) rd_q = mem[i_addr];
	assign o_drive = rd_en && on_q;
	// Released pins show the inverse, never a stale word
	assign o_dq = o_drive ? rd_q : ~last_q;
	always @(negedge wen) mem[i_addr] <= i_dq;
	always @(posedge i_sel_n) last_q <= rd_q;
endmodule
`default_nettype wire

/* tb/ais_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ais_ctrl_chk
	import ais_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_sys_rst,
	input  wire logic              o_sel_n,
	input  wire logic              o_wr_n,
	input  wire logic [ADDR_W-1:0] o_addr,
	input  wire logic [DATA_W-1:0] o_dq,
	input  wire logic              o_dq_oe_n
);
	logic [CNT_W-1:0] low_q;
	logic             wseen_q;
	logic             wframe_q;
	wire              wen = !o_sel_n && !o_wr_n;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	always_ff @(posedge i_clk) low_q <= o_sel_n ? '0 : low_q + 1'b1;
	// Strobe seen anywhere in a select pulse marks it a write
	always_ff @(posedge i_clk) wseen_q <= !o_sel_n && (wseen_q || !o_wr_n);
	// Strobe level just before select fell; low means a select write
	always_ff @(posedge i_clk) wframe_q <= o_sel_n ? !o_wr_n : wframe_q;
	chk_addr_glitch: assert property ($changed(o_addr) |-> o_sel_n || o_wr_n)
		else $error("address moved while selected and writing");
	chk_addr_held: assert property (!o_sel_n && $past(!o_sel_n) |-> $stable(o_addr))
		else $error("address moved inside a cycle");
	chk_addr_setup: assert property ($fell(o_sel_n) |-> $stable(o_addr))
		else $error("address not settled before select");
	chk_sel_width: assert property ($rose(o_sel_n) && !$past(i_sys_rst)
		|-> low_q >= (wseen_q ? CW_CYC : RC_CYC))
		else $error("select pulse too short");
	chk_wr_frame: assert property (!o_sel_n && wframe_q |-> !o_wr_n)
		else $error("strobe rose inside select write");
	chk_data_setup: assert property ($fell(wen) |-> !$past(o_dq_oe_n))
		else $error("data not driven before write end");
	chk_data_hold: assert property ($fell(wen) |-> !o_dq_oe_n && $stable(o_dq))
		else $error("data not held after write end");
	chk_strobe_wait: assert property ($fell(o_wr_n) && !o_sel_n
		|-> o_dq_oe_n ##1 (!o_wr_n && !o_dq_oe_n))
		else $error("strobe write drove data too early");
	chk_rd_setup: assert property ($fell(o_sel_n) && o_wr_n |-> $past(o_wr_n))
		else $error("strobe not high before read select");
endmodule
bind ais_ctrl ais_ctrl_chk u_chk (.i_clk, .i_sys_rst, .o_sel_n, .o_wr_n, .o_addr, .o_dq,
	.o_dq_oe_n);
`default_nettype wire

/* tb/common_io_async_sram_cycles_test.sv */
`timescale 1ns/1ps
`default_nettype none
module common_io_async_sram_cycles_test import ais_pkg::*;;
	typedef struct packed {ais_req_type r; logic [3:0] exp;} ais_row_type;
	logic              i_clk = 0;
	logic              i_sys_rst = 1;
	logic              req_valid = 0;
	ais_req_type       req = '0;
	logic              ready, rd_valid, sel_n, wr_n, dq_oe_n, m_drive;
	logic [DATA_W-1:0] rd_data, c_dq, m_dq, dq;
	logic [ADDR_W-1:0] addr;
	int                err_count = 0;
	int                num_checks = 0;
	ais_row_type       rows [8] = '{
		'{'{1'b1, AIS_WR_SELECT, 12'h000, 4'h5}, 4'h5}, '{'{1'b1, AIS_WR_STROBE, 12'hfff, 4'ha}, 4'ha},
		'{'{1'b0, AIS_WR_SELECT, 12'h000, 4'h0}, 4'h5}, '{'{1'b0, AIS_WR_SELECT, 12'hfff, 4'h0}, 4'ha},
		'{'{1'b1, AIS_WR_STROBE, 12'h123, 4'h3}, 4'h3}, '{'{1'b1, AIS_WR_SELECT, 12'h123, 4'hc}, 4'hc},
		'{'{1'b0, AIS_WR_STROBE, 12'h123, 4'h0}, 4'hc}, '{'{1'b0, AIS_WR_SELECT, 12'h000, 4'h0}, 4'h5}};
	assign dq = !dq_oe_n ? c_dq : m_dq;
	initial forever #10 i_clk = ~i_clk;
	ais_ctrl dut (.i_clk, .i_sys_rst, .i_ce(1'b1), .i_req_valid(req_valid), .i_req(req),
		.o_req_ready(ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_sel_n(sel_n),
		.o_wr_n(wr_n), .o_addr(addr), .o_dq(c_dq), .o_dq_oe_n(dq_oe_n), .i_dq(dq));
	ais_sram_model mem (.i_sel_n(sel_n), .i_wr_n(wr_n), .i_addr(addr), .i_dq(dq), .o_dq(m_dq),
		.o_drive(m_drive));
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Waits at falling edges so the design's updates have landed
	task automatic wait_hi(ref logic s);
		int n;
		for (n = 0; n < 30 && s !== 1'b1; n++) @(negedge i_clk);
		if (s !== 1'b1) begin
			err_count++;
			give_verdict();
		end
	endtask
	task automatic op(input ais_row_type w);
		req = w.r;
		req_valid = 1;
		wait_hi(ready);
		@(negedge i_clk);
		req_valid = 0;
		if (!w.r.write) begin
			wait_hi(rd_valid);
			cmp(rd_data, w.exp);
			@(negedge i_clk);
			cmp(rd_valid, 0);
		end
		wait_hi(ready);
		if (w.r.write) cmp(mem.mem[w.r.addr], w.exp);
	endtask
	initial begin
		repeat (6) @(negedge i_clk);
		cmp({sel_n, wr_n, dq_oe_n, ready}, 12'h00e);
		i_sys_rst = 0;
		@(negedge i_clk);
		cmp(ready, 1);
		$display("test reset done");
		foreach (rows[i]) op(rows[i]);
		$display("test rows done");
		i_sys_rst = 1;
		repeat (2) @(negedge i_clk);
		cmp({sel_n, wr_n, ready}, 12'h006);
		i_sys_rst = 0;
		op(rows[3]);
		$display("test second reset done");
		give_verdict();
	end
endmodule
`default_nettype wire
